// *** common/rct_cfg.svh ***
`ifndef RCT_CFG_SVH
`define RCT_CFG_SVH

`define RCT_OFF_STATUS   8'h40
`define RCT_OFF_IRQ_STAT 8'h44
`define RCT_OFF_IRQ_MASK 8'h48
`define RCT_OFF_WDT_CTRL 8'h4c
`define RCT_OFF_SRAM     8'h50
`define RCT_OFF_WDT_LOAD 8'h54

`define RCT_POR_BIT 0
`define RCT_EXT_BIT 1
`define RCT_WD_BIT  2
`define RCT_SW_BIT  3

`define RCT_CAUSE_RST 4'h1
`define RCT_SOFTWARE_RESET_FLAG_KEY 32'h05fa0004

`define RCT_CLK_HZ   25000000
`define RCT_CLK_MHZ  25
`define RCT_WDT_S    32
`define RCT_HOLD_NS  640
`define RCT_HOLD_CYC ((`RCT_HOLD_NS * `RCT_CLK_MHZ + 999) / 1000)

`endif

// *** common/rct_pkg.sv ***
package rct_pkg;

  typedef enum logic [0:0] {
    RCT_RUN  = 1'b0,
    RCT_HOLD = 1'b1
  } rct_fsm_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } rct_bus_req_t;

  typedef struct packed {
    rct_fsm_t    fsm;
    logic [4:0]  cnt;
    logic        por;
    logic [3:0]  cause;
    logic [3:0]  pend;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic        wdt_en;
    logic [31:0] wdt_load;
    logic        sram_valid;
    logic        dl_seen;
    logic        boot_start;
    logic        ext_s1;
    logic        ext_s2;
    logic [31:0] rdata;
  } rct_state_t;

endpackage

// *** src/rct_top.sv ***
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`include "rct_cfg.svh"

module rct_top #(
  parameter logic [31:0] WDT_LOAD = 32'(`RCT_WDT_S * `RCT_CLK_HZ)
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  ext_reset_n_i,
  input  wire logic                  wdt_timeout_i,
  input  wire logic                  aircr_wr_i,
  input  wire logic [31:0]           aircr_data_i,
  input  wire logic                  fw_download_i,
  input  wire rct_pkg::rct_bus_req_t bus_i,
  output logic [31:0]                rdata_o,
  output logic                       irq_o,
  output logic                       sys_reset_n_o,
  output logic                       boot_start_o,
  output logic                       power_up_indicator_pin_o,
  output logic                       power_up_indicator_pin_oe_o,
  output logic                       wdt_enable_o,
  output logic [31:0]                wdt_load_o,
  output logic                       sram_valid_o
);

  localparam logic [4:0] HOLD_LAST = 5'(`RCT_HOLD_CYC - 1);

  localparam rct_pkg::rct_state_t RST_STATE = '{
    fsm:        rct_pkg::RCT_HOLD,
    cnt:        5'h00,
    por:        1'b1,
    cause:      `RCT_CAUSE_RST,
    pend:       4'h1,
    irq_stat:   4'h0,
    irq_mask:   4'h0,
    wdt_en:     1'b1,
    wdt_load:   WDT_LOAD,
    sram_valid: 1'b0,
    dl_seen:    1'b0,
    boot_start: 1'b0,
    ext_s1:     1'b1,
    ext_s2:     1'b1,
    rdata:      32'h00000000
  };

  logic               rst_s1;
  logic               rst_n;
  rct_pkg::rct_state_t q;
  rct_pkg::rct_state_t d;
  logic               sw_hit;
  logic [3:0]         ev;
  logic [3:0]         cause_clr;
  logic [3:0]         irq_clr;
  logic [3:0]         irq_set;
  logic               wr_status;
  logic               wr_irq;

  // Power-on reset release through two flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  always_comb begin
    d              = q;
    d.boot_start   = 1'b0;
    d.ext_s1       = ext_reset_n_i;
    d.ext_s2       = q.ext_s1;
    irq_set        = 4'h0;
    sw_hit         = aircr_wr_i && (aircr_data_i == `RCT_SOFTWARE_RESET_FLAG_KEY);
    ev             = 4'h0;
    ev[`RCT_SW_BIT]  = sw_hit;
    ev[`RCT_WD_BIT]  = wdt_timeout_i;
    ev[`RCT_EXT_BIT] = ~q.ext_s2;
    wr_status      = bus_i.wr && (bus_i.addr == `RCT_OFF_STATUS);
    wr_irq         = bus_i.wr && (bus_i.addr == `RCT_OFF_IRQ_STAT);
    cause_clr      = wr_status ? bus_i.wdata[3:0] : 4'h0;
    irq_clr        = wr_irq ? bus_i.wdata[3:0] : 4'h0;
    // Set wins over clear in the same cycle
    d.cause        = (q.cause & ~cause_clr) | ev;

    // Registered read data, one cycle after the strobe
    d.rdata = 32'h00000000;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        `RCT_OFF_STATUS:   d.rdata = {28'h0000000, q.cause};
        `RCT_OFF_IRQ_STAT: d.rdata = {28'h0000000, q.irq_stat};
        `RCT_OFF_IRQ_MASK: d.rdata = {28'h0000000, q.irq_mask};
        `RCT_OFF_WDT_CTRL: d.rdata = {31'h00000000, q.wdt_en};
        `RCT_OFF_SRAM:     d.rdata = {30'h00000000, q.dl_seen,
                                      q.sram_valid};
        `RCT_OFF_WDT_LOAD: d.rdata = q.wdt_load;
        default:           d.rdata = 32'h00000000;
      endcase
    end

    unique case (q.fsm)
      rct_pkg::RCT_RUN: begin
        if (fw_download_i) begin
          d.dl_seen = 1'b1;
        end
        if (bus_i.wr) begin
          unique case (bus_i.addr)
            `RCT_OFF_IRQ_MASK: d.irq_mask = bus_i.wdata[3:0];
            `RCT_OFF_WDT_CTRL: d.wdt_en   = bus_i.wdata[0];
            `RCT_OFF_WDT_LOAD: d.wdt_load = bus_i.wdata;
            `RCT_OFF_SRAM: begin
              if (bus_i.wdata[0]) begin
                d.sram_valid = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
        if (|ev) begin
          d.fsm  = rct_pkg::RCT_HOLD;
          d.cnt  = 5'h00;
          d.por  = 1'b0;
          d.pend = ev;
          if (q.dl_seen) begin
            d.sram_valid = 1'b0;
          end
        end
      end
      rct_pkg::RCT_HOLD: begin
        // Mask and watchdog registers return to default; sram_valid holds, cause gathers new events, dl_seen clears and irq_stat takes pend at release
        d.pend     = q.pend | ev;
        d.irq_mask = 4'h0;
        d.wdt_en   = 1'b1;
        d.wdt_load = WDT_LOAD;
        if (|ev) begin
          d.cnt = 5'h00;
        end else if (q.cnt != HOLD_LAST) begin
          d.cnt = q.cnt + 5'h01;
        end else begin
          d.fsm        = rct_pkg::RCT_RUN;
          d.boot_start = 1'b1;
          d.dl_seen    = 1'b0;
          d.por        = 1'b0;
          d.pend       = 4'h0;
          irq_set      = q.pend;
        end
      end
    endcase

    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign rdata_o                     = q.rdata;
  assign irq_o                       = |(q.irq_stat & q.irq_mask);
  assign sys_reset_n_o               = (q.fsm == rct_pkg::RCT_RUN);
  assign boot_start_o                = q.boot_start;
  // Low only while a power-on reset is held
  assign power_up_indicator_pin_o    = ~(q.por && (q.fsm ==
                                         rct_pkg::RCT_HOLD));
  assign power_up_indicator_pin_oe_o = 1'b1;
  assign wdt_enable_o                = q.wdt_en;
  assign wdt_load_o                  = q.wdt_load;
  assign sram_valid_o                = q.sram_valid;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  property p_sw_key;
    aircr_wr_i && aircr_data_i == `RCT_SOFTWARE_RESET_FLAG_KEY
      |=> q.cause[`RCT_SW_BIT] && !sys_reset_n_o;
  endproperty
  a_sw_key: assert property (p_sw_key)
    else $error("software reset not recorded");

  property p_bad_key;
    q.fsm == rct_pkg::RCT_RUN && aircr_wr_i &&
      aircr_data_i != `RCT_SOFTWARE_RESET_FLAG_KEY && !wdt_timeout_i && q.ext_s2
      |=> sys_reset_n_o;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("reset on wrong key");

  property p_wdt;
    wdt_timeout_i |=> q.cause[`RCT_WD_BIT];
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog cause not recorded");

  property p_ext;
    !q.ext_s2 |=> q.cause[`RCT_EXT_BIT] && !sys_reset_n_o;
  endproperty
  a_ext: assert property (p_ext)
    else $error("pin reset not recorded");

  property p_clear;
    bus_i.wr && bus_i.addr == `RCT_OFF_STATUS &&
      bus_i.wdata[`RCT_POR_BIT] |=> !q.cause[`RCT_POR_BIT];
  endproperty
  a_clear: assert property (p_clear)
    else $error("cause bit not cleared");

  property p_sticky;
    !(bus_i.wr && bus_i.addr == `RCT_OFF_STATUS)
      |=> (q.cause & $past(q.cause)) == $past(q.cause);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("cause bit lost without clear");

  property p_race;
    wdt_timeout_i && bus_i.wr && bus_i.addr == `RCT_OFF_STATUS &&
      bus_i.wdata[`RCT_WD_BIT] |=> q.cause[`RCT_WD_BIT];
  endproperty
  a_race: assert property (p_race)
    else $error("clear beat a new cause");

  property p_hold;
    sys_reset_n_o && wdt_timeout_i |=> !sys_reset_n_o [*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("system reset too short");

  property p_indicator;
    sys_reset_n_o && wdt_timeout_i |=> power_up_indicator_pin_o [*8];
  endproperty
  a_indicator: assert property (p_indicator)
    else $error("indicator low on non power-on reset");

  property p_wdt_default;
    $rose(sys_reset_n_o) |-> wdt_enable_o && wdt_load_o == WDT_LOAD
      && q.irq_mask == 4'h0 && $past(boot_start_o) == 1'b0 && boot_start_o;
  endproperty
  a_wdt_default: assert property (p_wdt_default)
    else $error("watchdog not at default after reset");

  property p_sram;
    sys_reset_n_o && q.dl_seen && wdt_timeout_i |=> !sram_valid_o;
  endproperty
  a_sram: assert property (p_sram)
    else $error("sram still valid after download reset");

  property p_read;
    bus_i.rd && bus_i.addr == `RCT_OFF_STATUS
      |=> rdata_o == {28'h0000000, $past(q.cause)};
  endproperty
  a_read: assert property (p_read)
    else $error("status read mismatch");

  property p_rdata_idle;
    !bus_i.rd |=> rdata_o == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero after idle cycle");

  property p_status_hi;
    bus_i.rd && bus_i.addr == `RCT_OFF_STATUS
      |=> rdata_o[31:4] == 28'h0000000;
  endproperty
  a_status_hi: assert property (p_status_hi)
    else $error("reserved status bits not zero");

  property p_hold_mask;
    !sys_reset_n_o |=> q.irq_mask == 4'h0;
  endproperty
  a_hold_mask: assert property (p_hold_mask)
    else $error("mask not reset while held");

  property p_hold_wdt_en;
    !sys_reset_n_o |=> wdt_enable_o;
  endproperty
  a_hold_wdt_en: assert property (p_hold_wdt_en)
    else $error("watchdog not enabled while held");

  property p_hold_load;
    !sys_reset_n_o |=> wdt_load_o == WDT_LOAD;
  endproperty
  a_hold_load: assert property (p_hold_load)
    else $error("watchdog load not default while held");

  property p_pin_other;
    !sys_reset_n_o && !q.por |-> power_up_indicator_pin_o;
  endproperty
  a_pin_other: assert property (p_pin_other)
    else $error("indicator low on other reset");

  property p_pin_run;
    sys_reset_n_o |-> power_up_indicator_pin_o;
  endproperty
  a_pin_run: assert property (p_pin_run)
    else $error("indicator low while running");

  property p_boot_pulse;
    boot_start_o |=> !boot_start_o;
  endproperty
  a_boot_pulse: assert property (p_boot_pulse)
    else $error("boot start longer than one cycle");

  property p_boot_release;
    boot_start_o |-> sys_reset_n_o;
  endproperty
  a_boot_release: assert property (p_boot_release)
    else $error("boot start while reset held");

  property p_ext_hold;
    !q.ext_s2 |=> !sys_reset_n_o [*8];
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("pin reset released too early");

  property p_sram_keep;
    sys_reset_n_o && !q.dl_seen && wdt_timeout_i && sram_valid_o
      |=> sram_valid_o;
  endproperty
  a_sram_keep: assert property (p_sram_keep)
    else $error("sram marked invalid without download");

  property p_mask_wr;
    sys_reset_n_o && bus_i.wr && bus_i.addr == `RCT_OFF_IRQ_MASK
      |=> q.irq_mask == $past(bus_i.wdata[3:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr)
    else $error("mask write lost while running");

endmodule

// *** tb/rct_far_model.sv ***
`timescale 1ns/1ns

module rct_far_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [1:0]  kind_i,
  input  wire logic [31:0] key_i,
  output logic             ext_reset_n_o,
  output logic             wdt_timeout_o,
  output logic             aircr_wr_o,
  output logic [31:0]      aircr_data_o
);
  logic [2:0] pin_cnt_q = 3'h0;
  initial wdt_timeout_o = 1'b0;
  initial aircr_wr_o = 1'b0;
  initial aircr_data_o = 32'h0;
  assign ext_reset_n_o = (pin_cnt_q == 3'h0);
  always @(posedge clk_i) begin
    wdt_timeout_o <= go_i && kind_i == 2'h0;
    aircr_wr_o    <= go_i && kind_i == 2'h1;
    // Data bus toggles when no write is made
    aircr_data_o  <= (go_i && kind_i == 2'h1) ? key_i : ~aircr_data_o;
    if (go_i && kind_i == 2'h2) begin
      pin_cnt_q <= 3'h4;
    end else if (pin_cnt_q != 3'h0) begin
      pin_cnt_q <= pin_cnt_q - 3'h1;
    end
  end
endmodule

// *** tb/test_reset_cause_tracker.sv ***
`timescale 1ns/1ns

module test_reset_cause_tracker;
  logic clk_i = 1'b0, reset_n_i = 1'b0, fw = 1'b0, go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [31:0] key = 32'h0, r, exp_st;
  rct_pkg::rct_bus_req_t bus = '0;
  logic ext_n, wdt, awr, irq, sys_n, boot, pin, pin_oe, wen, sram, rd_seen;
  logic [31:0] adata, rdata, wload;
  logic [31:0] exp_q[$];
  int error_cnt = 0, num_checks = 0, seed = 91, k;

  always #20 clk_i = ~clk_i;

  rct_far_model rct_far_model_i (.clk_i(clk_i), .go_i(go), .kind_i(kind),
    .key_i(key), .ext_reset_n_o(ext_n), .wdt_timeout_o(wdt),
    .aircr_wr_o(awr), .aircr_data_o(adata));

  rct_top #(.WDT_LOAD(32'h64)) rct_top_i (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .ext_reset_n_i(ext_n), .wdt_timeout_i(wdt),
    .aircr_wr_i(awr), .aircr_data_i(adata), .fw_download_i(fw),
    .bus_i(bus), .rdata_o(rdata), .irq_o(irq), .sys_reset_n_o(sys_n),
    .boot_start_o(boot), .power_up_indicator_pin_o(pin),
    .power_up_indicator_pin_oe_o(pin_oe), .wdt_enable_o(wen),
    .wdt_load_o(wload), .sram_valid_o(sram));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    bus.rd <= 1'b1;
    bus.addr <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    bus.rd <= 1'b0;
  endtask

  // Event from the far side, optionally with a clear in the same cycle
  task fire(input logic [1:0] kd, input logic [31:0] v, input logic clr);
    @(posedge clk_i);
    go <= 1'b1;
    kind <= kd;
    key <= v;
    @(posedge clk_i);
    go <= 1'b0;
    if (clr) begin
      bus.wr <= 1'b1;
      bus.addr <= 8'h40;
      bus.wdata <= 32'hf;
      @(posedge clk_i);
      bus.wr <= 1'b0;
    end
  endtask

  task wait_rel(input logic pin_exp);
    for (int i = 0; i < 60; i++) begin
      @(negedge clk_i);
      if (boot === 1'b1) break;
      if (sys_n === 1'b0) chk(pin, pin_exp);
    end
    chk(boot, 1'b1);
    chk(sys_n, 1'b1);
    chk(wen, 1'b1);
    chk(wload, 32'h64);
  endtask

  always @(posedge clk_i) begin
    if (rd_seen === 1'b1) chk(rdata, exp_q.pop_front());
    rd_seen <= bus.rd;
  end

  initial begin
    #(40 * 30000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    rd_seen = 1'b0;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wait_rel(1'b0);
    rd(8'h40, 32'h1);
    rd(8'h60, 32'h0);
    @(negedge clk_i);
    chk(pin, 1'b1);
    chk(pin_oe, 1'b1);
    chk(sram, 1'b0);
    $display("power-on test done");
    r = $random(seed);
    wr(8'h40, r);
    rd(8'h40, {28'h0, 4'h1 & ~r[3:0]});
    wr(8'h40, 32'h1);
    rd(8'h40, 32'h0);
    fire(2'h1, 32'h05fa0004 ^ ($random(seed) | 32'h1), 1'b0);
    repeat (24) @(posedge clk_i);
    chk(sys_n, 1'b1);
    exp_st = 32'h0;
    for (k = 0; k < 3; k++) begin
      wr(8'h4c, 32'h0);
      wr(8'h54, 32'h20);
      wr(8'h50, 32'h1);
      fire(k[1:0], 32'h05fa0004, 1'b0);
      wait_rel(1'b1);
      exp_st = exp_st | ((k == 0) ? 32'h4 : (k == 1) ? 32'h8 : 32'h2);
      rd(8'h40, exp_st);
      chk(sram, 1'b1);
    end
    $display("cause test done");
    wr(8'h48, 32'h2);
    @(negedge clk_i);
    chk(irq, 1'b1);
    wr(8'h48, 32'h0);
    @(negedge clk_i);
    chk(irq, 1'b0);
    wr(8'h48, 32'h2);
    wr(8'h44, 32'hf);
    @(negedge clk_i);
    chk(irq, 1'b0);
    $display("interrupt test done");
    fire(2'h0, 32'h0, 1'b1);
    wait_rel(1'b1);
    rd(8'h40, 32'h4);
    fw <= 1'b1;
    fire(2'h0, 32'h0, 1'b0);
    fw <= 1'b0;
    wait_rel(1'b1);
    chk(sram, 1'b0);
    $display("collision test done");
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wait_rel(1'b0);
    rd(8'h40, 32'h1);
    rd(8'h48, 32'h0);
    @(negedge clk_i);
    chk(sram, 1'b0);
    $display("second power-on test done");
    // Let the last queued read reach the checker
    repeat (3) @(posedge clk_i);
    print_verdict();
  end
endmodule
